// ---- core/pot_cmd_regs.vh ----
// constants for the quad pot serial command decoder
// assumes a 25 MHz system clock; included by bare name
`ifndef POT_CMD_REGS_VH
`define POT_CMD_REGS_VH

`define ID_NIBBLE        4'h5
`define OP_STEP          4'h2
`define OP_RESTORE       4'h1
`define OP_SAVE          4'h8
`define OP_STATUS        4'h5
`define STATUS_ADDR      4'h1
`define CLK_HZ           25000000
`define NV_WRITE_MS      10
`define NV_WRITE_CYCLES  (`CLK_HZ / 1000 * `NV_WRITE_MS)
`define WIPER_MAX        6'h3F

`endif

// ---- core/pot_serial_command_subset.v ----
// serial command decoder for a quad digital pot: step, global restore,
// global save with nonvolatile write timer, and write-busy status read.
// assumes csN, sck, si arrive asynchronously and are sampled on clock.
//
// Notes on behaviour
// R01: step frame: id, 00, straps, 0010, xx, pot select, then direction bits.
// R02: restore frame loads every wiper from its selected stored slot.
// R03: if write-busy is clear at cs rise, save frame copies all wipers to a slot and the write starts.
// R04: status frame answers seven zeros then the write-busy flag on so.
// R05: each clock high with si high steps up, si low steps down.
// R06: write-busy stays set exactly while the nonvolatile write runs.
// R07: host sends strap bits matching this device's address pins.
// R08: mismatched id or straps: frame ignored, so stays undriven.
`include "pot_cmd_regs.vh"
`default_nettype none

module pot_serial_command_subset #(
    parameter NV_WRITE_CYCLES = `NV_WRITE_CYCLES
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        csN,
    input  wire        sck,
    input  wire        si,
    input  wire        strapAddrHi,
    input  wire        strapAddrLo,
    output reg         so,
    output reg         soEn,
    output reg  [5:0]  wiper0,
    output reg  [5:0]  wiper1,
    output reg  [5:0]  wiper2,
    output reg  [5:0]  wiper3,
    output reg         writeBusy
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg [2:0] csS;
    reg [2:0] sckS;
    reg [2:0] siS;
    reg       csQ;
    reg       sckQ;
    reg       siQ;
    reg [2:0] strapHiS;
    reg [2:0] strapLoS;
    reg       strapHiQ;
    reg       strapLoQ;

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            csS  <= 3'h7;
            sckS <= 3'h0;
            siS  <= 3'h0;
            csQ  <= 1'b1;
            sckQ <= 1'b0;
            siQ  <= 1'b0;
            strapHiS <= 3'h0;
            strapLoS <= 3'h0;
            strapHiQ <= 1'b0;
            strapLoQ <= 1'b0;
        end
        else
        begin
            csS  <= {csS[1:0], csN};
            sckS <= {sckS[1:0], sck};
            siS  <= {siS[1:0], si};
            strapHiS <= {strapHiS[1:0], strapAddrHi};
            strapLoS <= {strapLoS[1:0], strapAddrLo};
            if (csS[1] == csS[2])
                csQ <= csS[2];
            if (sckS[1] == sckS[2])
                sckQ <= sckS[2];
            if (siS[1] == siS[2])
                siQ <= siS[2];
            // address straps are board pins too, filtered like the link pins
            if (strapHiS[1] == strapHiS[2])
                strapHiQ <= strapHiS[2];
            if (strapLoS[1] == strapLoS[2])
                strapLoQ <= strapLoS[2];
        end
    end

    wire csNew  = (csS[1] == csS[2]) ? csS[2] : csQ;
    wire sckNew = (sckS[1] == sckS[2]) ? sckS[2] : sckQ;
    wire csFall = csQ & ~csNew;
    wire csRise = ~csQ & csNew;
    wire sckRise = ~csQ & ~sckQ & sckNew;
    wire sckFall = ~csQ & sckQ & ~sckNew;

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    localparam [4:0] ST_HEAD   = 5'b00001;
    localparam [4:0] ST_STEP   = 5'b00010;
    localparam [4:0] ST_STATUS = 5'b00100;
    localparam [4:0] ST_DONE   = 5'b01000;
    localparam [4:0] ST_IGNORE = 5'b10000;

    reg [4:0]  state_r;
    reg [15:0] shift_r;
    reg [4:0]  bitCnt_r;
    reg [1:0]  potSel_r;
    reg        savePend_r;
    reg [1:0]  saveSlot_r;
    reg [7:0]  statusOut_r;
    reg [3:0]  outCnt_r;
    reg [5:0]  slot [0:15];
    reg [31:0] nvCnt_r;
    integer    i;

    wire [15:0] hdr = {shift_r[14:0], siQ};

    function [5:0] stepWiper;
        input [5:0] w;
        input       up;
        begin
            if (up)
                stepWiper = (w == `WIPER_MAX) ? w : w + 6'h01;
            else
                stepWiper = (w == 6'h00) ? w : w - 6'h01;
        end
    endfunction

    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r     <= ST_HEAD;
            shift_r     <= 16'h0000;
            bitCnt_r    <= 5'h00;
            potSel_r    <= 2'h0;
            savePend_r  <= 1'b0;
            saveSlot_r  <= 2'h0;
            statusOut_r <= 8'h00;
            outCnt_r    <= 4'h0;
            so          <= 1'b0;
            soEn        <= 1'b0;
            wiper0      <= 6'h00;
            wiper1      <= 6'h00;
            wiper2      <= 6'h00;
            wiper3      <= 6'h00;
            writeBusy   <= 1'b0;
            nvCnt_r     <= 32'h0000_0000;
            for (i = 0; i < 16; i = i + 1)
                slot[i] <= 6'h00;
        end
        else
        begin
            if (writeBusy)
            begin
                if (nvCnt_r == 32'h0000_0000)
                    writeBusy <= 1'b0; // R06
                else
                    nvCnt_r <= nvCnt_r - 32'h0000_0001;
            end
            if (csFall)
            begin
                state_r    <= ST_HEAD;
                bitCnt_r   <= 5'h00;
                savePend_r <= 1'b0;
                soEn       <= 1'b0;
            end
            else if (csRise)
            begin
                soEn <= 1'b0;
                if (savePend_r && !writeBusy)
                begin
                    writeBusy <= 1'b1; // R03
                    nvCnt_r   <= NV_WRITE_CYCLES - 1;
                    slot[{2'h0, saveSlot_r}]  <= wiper0;
                    slot[{2'h1, saveSlot_r}]  <= wiper1;
                    slot[{2'h2, saveSlot_r}]  <= wiper2;
                    slot[{2'h3, saveSlot_r}]  <= wiper3;
                end
                savePend_r <= 1'b0;
                state_r    <= ST_IGNORE;
            end
            else if (sckRise)
            begin
                case (state_r)
                ST_HEAD:
                begin
                    shift_r  <= hdr;
                    bitCnt_r <= bitCnt_r + 5'h01;
                    if (bitCnt_r == 5'h0F)
                    begin
                        if (hdr[15:12] != `ID_NIBBLE || hdr[11:10] != 2'h0 ||
                            hdr[9] != strapHiQ || hdr[8] != strapLoQ)
                            state_r <= ST_IGNORE; // R08
                        else if (hdr[7:4] == `OP_STEP)
                        begin
                            potSel_r <= hdr[1:0]; // R01
                            state_r  <= ST_STEP;
                        end
                        else if (hdr[7:4] == `OP_RESTORE && hdr[1:0] == 2'h0)
                        begin
                            wiper0  <= slot[{2'h0, hdr[3:2]}]; // R02
                            wiper1  <= slot[{2'h1, hdr[3:2]}];
                            wiper2  <= slot[{2'h2, hdr[3:2]}];
                            wiper3  <= slot[{2'h3, hdr[3:2]}];
                            state_r <= ST_DONE;
                        end
                        else if (hdr[7:4] == `OP_SAVE && hdr[1:0] == 2'h0)
                        begin
                            savePend_r <= 1'b1; // R03
                            saveSlot_r <= hdr[3:2];
                            state_r    <= ST_DONE;
                        end
                        else if (hdr[7:4] == `OP_STATUS && hdr[3:0] == `STATUS_ADDR)
                        begin
                            statusOut_r <= {7'h00, writeBusy}; // R04
                            outCnt_r    <= 4'h0;
                            state_r     <= ST_STATUS;
                        end
                        else
                            state_r <= ST_IGNORE;
                    end
                end
                ST_STEP:
                begin
                    case (potSel_r) // R05
                    2'h0: wiper0 <= stepWiper(wiper0, siQ);
                    2'h1: wiper1 <= stepWiper(wiper1, siQ);
                    2'h2: wiper2 <= stepWiper(wiper2, siQ);
                    default: wiper3 <= stepWiper(wiper3, siQ);
                    endcase
                end
                default:
                    state_r <= state_r;
                endcase
            end
            else if (sckFall && state_r == ST_STATUS)
            begin
                if (outCnt_r == 4'h8)
                begin
                    soEn    <= 1'b0;
                    state_r <= ST_DONE;
                end
                else
                begin
                    soEn        <= 1'b1; // R04
                    so          <= statusOut_r[7];
                    statusOut_r <= {statusOut_r[6:0], 1'b0};
                    outCnt_r    <= outCnt_r + 4'h1;
                end
            end
        end
    end

endmodule // pot_serial_command_subset

`default_nettype wire

// ---- test/pot_cmd_sva.sv ----
// assertions on the pot decoder ports
// bound into the decoder; one system clock domain, reset rst
`default_nettype none
module pot_cmd_sva #(parameter int NV_WRITE_CYCLES = 50) (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       csN,
    input wire logic       so,
    input wire logic       soEn,
    input wire logic [5:0] wiper0,
    input wire logic       writeBusy
);
    int busyCnt_r;
    always_ff @(posedge clock or posedge rst)
        busyCnt_r <= rst ? 0 : writeBusy ? busyCnt_r + 1 : 0;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence leadZero; (soEn && !so) [*8]; endsequence
    sequence deselected; csN [*6]; endsequence
    chk_busy_len: assert property ($fell(writeBusy) |-> busyCnt_r == NV_WRITE_CYCLES)
        else $error("busy time wrong");
    chk_busy_held: assert property ($rose(writeBusy) |-> writeBusy [*8])
        else $error("busy dropped early");
    chk_save_start: assert property ($rose(writeBusy) |-> csN && !soEn)
        else $error("busy rose inside a frame");
    chk_status_zero: assert property ($rose(soEn) |-> leadZero)
        else $error("status lead bit not zero");
    chk_status_len: assert property ($rose(soEn) |-> ##[60:68] $fell(soEn))
        else $error("status byte length wrong");
    chk_quiet_idle: assert property (deselected |-> !soEn)
        else $error("output driven while deselected");
    chk_wiper_cs: assert property ($changed(wiper0) |-> !$past(csN, 4))
        else $error("wiper moved outside a frame");
    chk_reset_zero: assert property ($fell(rst) |-> !writeBusy && !soEn && wiper0 == 6'h00)
        else $error("reset state wrong");
endmodule // pot_cmd_sva
bind pot_serial_command_subset pot_cmd_sva #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_u (
    .clock(clock), .rst(rst), .csN(csN), .so(so), .soEn(soEn), .wiper0(wiper0),
    .writeBusy(writeBusy));
`default_nettype wire

// ---- test/spi_host_model.sv ----
// host model: chip select, serial clock and serial in for the decoder
// changes its outputs on the falling edge of the system clock
`default_nettype none
module spi_host_model (
    input  wire logic clock,
    input  wire logic so,
    output var logic  csN = 1'b1,
    output var logic  sck = 1'b0,
    output var logic  si = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // header msb first, then n trailing bits lsb first; so taken at each rise
    task automatic xfer(input logic [15:0] h, input int n, input logic [63:0] d,
                        output logic [7:0] rd);
        rd = 8'h00;
        tick(1);
        csN = 1'b0;
        tick(7);
        for (int i = 0; i < 16 + n; i++)
        begin
            si = (i < 16) ? h[15 - i] : d[i - 16];
            // 320 ns link clock: four system clocks high, four low
            tick(4);
            sck = 1'b1;
            rd = {rd[6:0], so};
            tick(4);
            sck = 1'b0;
        end
        tick(7);
        csN = 1'b1;
        si = ~si;
        tick(60);
    endtask
endmodule // spi_host_model
`default_nettype wire

// ---- test/tb_pot_serial_command_subset.sv ----
// self-checking bench for the pot serial command decoder
// host model makes the frames; straps and reset come from here
`include "pot_cmd_regs.vh"
`default_nettype none
module tb_pot_serial_command_subset;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NV = 500;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] straps = 2'h0;
    logic [1:0] pot = 2'h0;
    logic [7:0] rd;
    logic [5:0] expW [4] = '{default: 6'h00};
    logic [5:0] slot [4][4] = '{default: '{default: 6'h00}};
    wire logic csN, sck, si, so, soEn, writeBusy;
    wire logic [5:0] wiper0, wiper1, wiper2, wiper3;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    always #20 clock = ~clock;
    pot_serial_command_subset #(.NV_WRITE_CYCLES(NV)) dut_u (.clock(clock), .rst(rst),
        .csN(csN), .sck(sck), .si(si), .strapAddrHi(straps[1]), .strapAddrLo(straps[0]),
        .so(so), .soEn(soEn), .wiper0(wiper0), .wiper1(wiper1), .wiper2(wiper2),
        .wiper3(wiper3), .writeBusy(writeBusy));
    spi_host_model host_u (.clock(clock), .so(so), .csN(csN), .sck(sck), .si(si));
    function automatic logic [15:0] hdr(logic [3:0] op, logic [3:0] a, logic [1:0] s);
        return {`ID_NIBBLE, 2'h0, s, op, a};
    endfunction
    function automatic logic [5:0] stepW(logic [5:0] w, logic up);
        return up ? (w == `WIPER_MAX ? w : w + 6'h01) : (w == 6'h00 ? w : w - 6'h01);
    endfunction
    task automatic tally_and_finish();
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic checkW();
        logic [23:0] w;
        w = {wiper3, wiper2, wiper1, wiper0};
        for (int k = 0; k < 4; k++)
            cmp("wiper", {2'h0, expW[k]}, {2'h0, w[6*k +: 6]});
    endtask
    // t 0 and 1 run one pot into both ends; a foreign strap changes nothing
    task automatic stepFrame(input int t, input logic [1:0] s);
        logic [63:0] d;
        int n;
        if (t != 1)
            pot = 2'($urandom);
        n = (t < 2) ? 64 : 1 + $urandom % 20;
        d = (t == 0) ? '1 : (t == 1) ? '0 : {$urandom, $urandom};
        host_u.xfer(hdr(`OP_STEP, {2'h0, pot}, s), n, d, rd);
        for (int i = 0; i < n && s == straps; i++)
            expW[pot] = stepW(expW[pot], d[i]);
        checkW();
    endtask
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial
    begin
        void'($urandom(43337));
        straps = 2'($urandom);
        repeat (10) @(negedge clock);
        rst = 1'b0;
        repeat (5) @(negedge clock);
        for (int t = 0; t < 12; t++)
            stepFrame(t, straps);
        pot = 2'($urandom);
        host_u.xfer(hdr(`OP_SAVE, {pot, 2'h0}, straps), 0, 64'h0, rd);
        slot[pot] = expW;
        cmp("busy pin", 8'h01, {7'h00, writeBusy});
        host_u.xfer(hdr(`OP_STATUS, `STATUS_ADDR, straps), 8, 64'h0, rd);
        cmp("status busy", 8'h01, rd);
        repeat (NV) @(negedge clock);
        host_u.xfer(hdr(`OP_STATUS, `STATUS_ADDR, straps), 8, 64'h0, rd);
        cmp("status idle", 8'h00, rd);
        for (int t = 2; t < 5; t++)
            stepFrame(t, straps);
        stepFrame(0, straps ^ 2'h1);
        for (int q = 0; q < 4; q++)
        begin
            host_u.xfer(hdr(`OP_RESTORE, 4'(q << 2), straps), 0, 64'h0, rd);
            expW = slot[q];
            checkW();
        end
        tally_and_finish();
    end
endmodule // tb_pot_serial_command_subset
`default_nettype wire
